// ==== acc_ctrl.sv ====
// What this block does
// - Sleep code sets idle time between cycles.
// - Writing one requests a charge counter reset.
// - Pen bias bit drives pen detect bias.
// - Start bit runs; clearing stops after cycle.
// - Power bit sets full converter power.
// - Gain bits chooses tenfold; touch bias overrides.
// - Result high holds upper bits, gain.
// - Result low holds three lowest bits.
// - Slot register selects channel in bits 4:0.
// - Slot bits drive three bias pairs.
// - Processed count readable as two bytes.
// - Extended bits enable extra channels, default off.
// - Dither enable bit, default off.
// - Digital correction disable bit.
// - Analog offset calibration enable bit.
// - Sign bit reverses counting sense.
// - Fault flag when charging count passes 32767.
// - Fifteen-bit prescale split over two registers.
// - Raw count readable as two bytes.
// - Either enable runs; either clear zeros.
// - Hardware clears the reset request bit.
// - Count steps once per prescale converter counts.
// - Count bit 14 rising raises overflow event.
`timescale 1ns/1ps
module acc_ctrl
  import acc_pkg::*;
#(
  parameter int unsigned SLEEP_STEP_CYCLES = SLEEP_STEP_CYC, // Cycles per sleep step.
  parameter int          NUM_SLOTS         = 32              // Slots per round-robin cycle.
)
(
  input  wire logic       core_clk,                      // System clock, 100 MHz.
  input  wire logic       rst_n,                         // Asynchronous reset, active low.
  input  wire logic       spi_cs_n,                      // Register port select.
  input  wire logic       spi_sclk,                      // Register port clock.
  input  wire logic       spi_mosi,                      // Register port data in.
  output logic            spi_miso,                      // Register port data out.
  output logic            spi_miso_oe,                   // Data out enable.
  output logic            conv_req,                      // Conversion request, held until done.
  output logic [4:0]      conv_channel,                  // Channel being converted.
  output logic            conv_gain,                     // Tenfold gain for this conversion.
  input  wire logic       conv_done,                     // Conversion finished pulse.
  input  wire logic [9:0] conv_result,                   // Result with conv_done.
  output logic            converter_power_on,            // Converter at full power.
  output logic            pen_bias_enable,               // Pen detect bias on.
  output logic            x_pair_bias_on,                // X pair bias switches on.
  output logic            y_pair_bias_on,                // Y pair bias switches on.
  output logic            cross_pair_bias_on,            // Cross pair bias switches on.
  output logic            supply_channel_enable,         // Extra channel 22 enabled.
  output logic            charge_current_channel_enable, // Extra channel 24 enabled.
  output logic            backup_cell_channel_enable,    // Extra channel 25 enabled.
  output logic            battery_detect_channel_enable, // Extra channel 26 enabled.
  input  wire logic       cc_up,                         // Integrator count, charging.
  input  wire logic       cc_down,                       // Integrator count, discharging.
  output logic            charge_count_run,              // Counter running.
  output logic            period_dither_enable,          // Integration period dither on.
  output logic            digital_correction_off,        // Offset and gain correction off.
  output logic            analog_offset_cal,             // Integrator inputs shorted.
  output logic            cycle_done,                    // Round-robin cycle complete pulse.
  output logic            overflow_event                 // Count reached half scale pulse.
);

  typedef struct packed {
    logic [7:0]                seq_ctrl;
    logic [7:0]                gain_a;
    logic [7:0]                gain_b;
    logic [3:0]                extra;
    logic [5:0]                cc_ctl;
    logic                      fault;
    logic [14:0]               prescale;
    logic [15:0]               count;
    logic signed [15:0]        pre;
    logic [NUM_CH-1:0][7:0]    slots;
    logic [NUM_CH-1:0][10:0]   results;
    acc_seq_state_t            state;
    logic [4:0]                slot_idx;
    logic [31:0]               sleep_cnt;
    logic                      conv_req;
    logic [4:0]                conv_channel;
    logic                      conv_gain;
    logic [2:0]                bias;
    logic                      cycle_done;
    logic                      overflow_event;
  } acc_ctrl_state_t;

  acc_ctrl_state_t st_r;
  acc_ctrl_state_t st_nxt;
  acc_regport_if   bus ();

  logic            start_req;
  logic            cc_enable;
  logic            cc_clear;
  logic [7:0]      slot_now;
  logic [4:0]      ch_now;
  logic [11:0]     gain_vec;
  logic [4:0]      gain_idx;
  logic            touch_biased;
  logic            gain_now;
  logic [15:0]     count_shown;
  logic [4:0]      res_idx;
  logic [4:0]      slot_ridx;
  logic [7:0]      rdata;

  acc_spi_port u_spi (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .spi_cs_n    (spi_cs_n),
    .spi_sclk    (spi_sclk),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .bus         (bus.port)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helper terms.

  assign start_req = bus.wr_stb && bus.addr == ADDR_SEQ_CTRL && bus.wdata[SEQ_START];
  assign cc_enable = st_r.seq_ctrl[SEQ_CC_EN] | st_r.cc_ctl[CC_ALT_EN];
  assign cc_clear  = st_r.seq_ctrl[SEQ_CC_CLR] | st_r.cc_ctl[CC_ALT_CLR];
  assign slot_now  = st_r.slots[st_r.slot_idx];
  assign ch_now    = slot_now[SLOT_SEL_MSB:0];
  assign gain_vec  = {st_r.gain_b[3:0], st_r.gain_a};
  assign gain_idx  = ch_now - GAIN_CH_FIRST;
  assign touch_biased = st_r.seq_ctrl[SEQ_PEN] | (|slot_now[SLOT_CROSS:SLOT_X_PAIR]);

  // Touch channels lose their gain choice while the panel is biased.
  always_comb
  begin
    gain_now = 1'b0;
    if (ch_now >= GAIN_CH_FIRST && ch_now <= GAIN_CH_LAST)
    begin
      gain_now = gain_vec[gain_idx[3:0]];
    end
    if (ch_now <= TOUCH_CH_LAST && touch_biased)
    begin
      gain_now = 1'b0;
    end
  end

  // The processed count is the raw count with the sign sense applied.
  assign count_shown = st_r.cc_ctl[CC_SIGN] ? 16'(-st_r.count) : st_r.count;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    st_nxt                = st_r;
    st_nxt.cycle_done     = 1'b0;
    st_nxt.overflow_event = 1'b0;

    // Round-robin sequencer.
    case (st_r.state)
      SEQ_IDLE:
      begin
        if (start_req
            || (st_r.seq_ctrl[SEQ_START] && st_r.seq_ctrl[SEQ_SLEEP_MSB:0] != SLEEP_NO_LOOP))
        begin
          st_nxt.state    = SEQ_REQ;
          st_nxt.slot_idx = 5'd0;
        end
      end
      SEQ_REQ:
      begin
        // A converter left in low power is never asked to convert.
        if (st_r.seq_ctrl[SEQ_POWER])
        begin
          st_nxt.conv_req     = 1'b1;
          st_nxt.conv_channel = ch_now;
          st_nxt.conv_gain    = gain_now;
          st_nxt.bias         = slot_now[SLOT_CROSS:SLOT_X_PAIR];
          st_nxt.state        = SEQ_WAIT;
        end
      end
      SEQ_WAIT:
      begin
        if (conv_done)
        begin
          st_nxt.conv_req                       = 1'b0;
          st_nxt.bias                           = 3'h0;
          st_nxt.results[st_r.conv_channel]     = {st_r.conv_gain, conv_result};
          if (st_r.slot_idx == 5'(NUM_SLOTS - 1))
          begin
            st_nxt.cycle_done = 1'b1;
            if (!st_r.seq_ctrl[SEQ_START]
                || st_r.seq_ctrl[SEQ_SLEEP_MSB:0] == SLEEP_NO_LOOP)
            begin
              st_nxt.state = SEQ_IDLE;
            end
            else if (st_r.seq_ctrl[SEQ_SLEEP_MSB:0] == SLEEP_CONT)
            begin
              st_nxt.state    = SEQ_REQ;
              st_nxt.slot_idx = 5'd0;
            end
            else
            begin
              st_nxt.state     = SEQ_SLEEP;
              st_nxt.sleep_cnt = 32'(st_r.seq_ctrl[SEQ_SLEEP_MSB:0]) * SLEEP_STEP_CYCLES
                                 - 32'd1;
            end
          end
          else
          begin
            st_nxt.slot_idx = st_r.slot_idx + 5'd1;
            st_nxt.state    = SEQ_REQ;
          end
        end
      end
      SEQ_SLEEP:
      begin
        if (!st_r.seq_ctrl[SEQ_START])
        begin
          st_nxt.state = SEQ_IDLE;
        end
        else if (st_r.sleep_cnt == 32'd0)
        begin
          st_nxt.state    = SEQ_REQ;
          st_nxt.slot_idx = 5'd0;
        end
        else
        begin
          st_nxt.sleep_cnt = st_r.sleep_cnt - 32'd1;
        end
      end
      default:
      begin
        st_nxt.state = SEQ_IDLE;
      end
    endcase

    // Charge counter. A clear wins over counting and also drops the fault flag.
    if (cc_clear)
    begin
      st_nxt.count                  = 16'h0000;
      st_nxt.pre                    = 16'sh0000;
      st_nxt.fault                  = 1'b0;
      st_nxt.seq_ctrl[SEQ_CC_CLR]   = 1'b0;
      st_nxt.cc_ctl[CC_ALT_CLR]     = 1'b0;
    end
    else if (cc_enable && (cc_up ^ cc_down))
    begin
      if (cc_up)
      begin
        if (st_r.pre + 16'sh0001 >= $signed({1'b0, st_r.prescale}))
        begin
          st_nxt.pre   = 16'sh0000;
          st_nxt.count = st_r.count + 16'h0001;
          if (st_r.count == 16'h7fff)
          begin
            st_nxt.fault = 1'b1;
          end
        end
        else
        begin
          st_nxt.pre = st_r.pre + 16'sh0001;
        end
      end
      else
      begin
        if (st_r.pre - 16'sh0001 <= -$signed({1'b0, st_r.prescale}))
        begin
          st_nxt.pre   = 16'sh0000;
          st_nxt.count = st_r.count - 16'h0001;
        end
        else
        begin
          st_nxt.pre = st_r.pre - 16'sh0001;
        end
      end
    end
    st_nxt.overflow_event = st_nxt.count[14] & ~st_r.count[14];

    // Register writes come last so a write in the same cycle wins over a hardware clear.
    if (bus.wr_stb)
    begin
      case (bus.addr)
        ADDR_SEQ_CTRL: st_nxt.seq_ctrl = bus.wdata;
        ADDR_GAIN_A:   st_nxt.gain_a   = bus.wdata;
        ADDR_GAIN_B:   st_nxt.gain_b   = {4'h0, bus.wdata[3:0]};
        ADDR_EXTRA:    st_nxt.extra    = bus.wdata[3:0];
        ADDR_CC_CTRL:  st_nxt.cc_ctl   = bus.wdata[CC_SIGN:0];
        ADDR_PRE_LO:   st_nxt.prescale[7:0] = bus.wdata;
        ADDR_PRE_HI:   st_nxt.prescale[14:8] = bus.wdata[PRE_HI_MSB:0];
        default:
        begin
          if (bus.addr >= ADDR_SLOT_BASE && bus.addr <= ADDR_SLOT_LAST)
          begin
            st_nxt.slots[5'(bus.addr - ADDR_SLOT_BASE)] = bus.wdata;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data. The counter pairs cannot be preset, so their writes are dropped.

  assign res_idx   = 5'((bus.addr - ADDR_RESULT_BASE) >> 1);
  assign slot_ridx = 5'(bus.addr - ADDR_SLOT_BASE);

  always_comb
  begin
    rdata = 8'h00;
    case (bus.addr)
      ADDR_SEQ_CTRL: rdata = st_r.seq_ctrl;
      ADDR_GAIN_A:   rdata = st_r.gain_a;
      ADDR_GAIN_B:   rdata = st_r.gain_b;
      ADDR_CNT_HI:   rdata = count_shown[15:8];
      ADDR_CNT_LO:   rdata = count_shown[7:0];
      ADDR_EXTRA:    rdata = {4'h0, st_r.extra};
      ADDR_CC_CTRL:  rdata = {st_r.fault, 1'b0, st_r.cc_ctl};
      ADDR_PRE_LO:   rdata = st_r.prescale[7:0];
      ADDR_PRE_HI:   rdata = {1'b0, st_r.prescale[14:8]};
      ADDR_RAW_HI:   rdata = st_r.count[15:8];
      ADDR_RAW_LO:   rdata = st_r.count[7:0];
      default:
      begin
        if (bus.addr >= ADDR_RESULT_BASE && bus.addr <= ADDR_RESULT_LAST)
        begin
          if (!bus.addr[0])
          begin
            rdata = {st_r.results[res_idx][10], st_r.results[res_idx][9:3]};
          end
          else
          begin
            rdata = {5'h00, st_r.results[res_idx][RES_LOW_MSB:0]};
          end
        end
        else if (bus.addr >= ADDR_SLOT_BASE && bus.addr <= ADDR_SLOT_LAST)
        begin
          rdata = st_r.slots[slot_ridx];
        end
      end
    endcase
  end

  assign bus.rdata = rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r          <= '0;
      st_r.seq_ctrl <= SEQ_CTRL_RST;
      st_r.gain_a   <= GAIN_RST;
      st_r.gain_b   <= GAIN_RST;
      st_r.extra    <= EXTRA_RST;
      st_r.cc_ctl   <= CC_CTRL_RST;
      st_r.prescale <= PRESCALE_RST;
      st_r.slots    <= {NUM_CH{SLOT_RST}};
      st_r.state    <= SEQ_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign conv_req                      = st_r.conv_req;
  assign conv_channel                  = st_r.conv_channel;
  assign conv_gain                     = st_r.conv_gain;
  assign converter_power_on            = st_r.seq_ctrl[SEQ_POWER];
  assign pen_bias_enable               = st_r.seq_ctrl[SEQ_PEN];
  assign x_pair_bias_on                = st_r.bias[0];
  assign y_pair_bias_on                = st_r.bias[1];
  assign cross_pair_bias_on            = st_r.bias[2];
  assign supply_channel_enable         = st_r.extra[0];
  assign charge_current_channel_enable = st_r.extra[1];
  assign backup_cell_channel_enable    = st_r.extra[2];
  assign battery_detect_channel_enable = st_r.extra[3];
  assign charge_count_run              = cc_enable;
  assign period_dither_enable          = st_r.cc_ctl[CC_DITHER];
  assign digital_correction_off        = st_r.cc_ctl[CC_DIG_OFF];
  assign analog_offset_cal             = st_r.cc_ctl[CC_ACAL];
  assign cycle_done                    = st_r.cycle_done;
  assign overflow_event                = st_r.overflow_event;

endmodule : acc_ctrl

// ==== acc_pkg.sv ====
package acc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W        = 10;
  localparam int DATA_W        = 8;
  localparam int NUM_CH        = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [9:0] ADDR_SEQ_CTRL    = 10'h061;
  localparam logic [9:0] ADDR_GAIN_A      = 10'h062;
  localparam logic [9:0] ADDR_GAIN_B      = 10'h063;
  localparam logic [9:0] ADDR_CNT_HI      = 10'h0c4;
  localparam logic [9:0] ADDR_CNT_LO      = 10'h0c5;
  localparam logic [9:0] ADDR_EXTRA       = 10'h1de;
  localparam logic [9:0] ADDR_CC_CTRL     = 10'h1df;
  localparam logic [9:0] ADDR_PRE_LO      = 10'h1e0;
  localparam logic [9:0] ADDR_PRE_HI      = 10'h1e1;
  localparam logic [9:0] ADDR_RAW_HI      = 10'h1e2;
  localparam logic [9:0] ADDR_RAW_LO      = 10'h1e3;
  localparam logic [9:0] ADDR_RESULT_BASE = 10'h080;
  localparam logic [9:0] ADDR_RESULT_LAST = 10'h0bf;
  localparam logic [9:0] ADDR_SLOT_BASE   = 10'h1a0;
  localparam logic [9:0] ADDR_SLOT_LAST   = 10'h1bf;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0]  SEQ_CTRL_RST = 8'h00;
  localparam logic [7:0]  GAIN_RST     = 8'h00;
  localparam logic [3:0]  EXTRA_RST    = 4'h0;
  localparam logic [5:0]  CC_CTRL_RST  = 6'h00;
  localparam logic [14:0] PRESCALE_RST = 15'h001a;
  localparam logic [7:0]  SLOT_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int SEQ_SLEEP_MSB = 2;
  localparam int SEQ_CC_EN     = 3;
  localparam int SEQ_CC_CLR    = 4;
  localparam int SEQ_PEN       = 5;
  localparam int SEQ_START     = 6;
  localparam int SEQ_POWER     = 7;
  localparam int CC_ALT_EN     = 0;
  localparam int CC_ALT_CLR    = 1;
  localparam int CC_DITHER     = 2;
  localparam int CC_DIG_OFF    = 3;
  localparam int CC_ACAL       = 4;
  localparam int CC_SIGN       = 5;
  localparam int CC_FAULT      = 7;
  localparam int SLOT_SEL_MSB  = 4;
  localparam int SLOT_X_PAIR   = 5;
  localparam int SLOT_Y_PAIR   = 6;
  localparam int SLOT_CROSS    = 7;
  localparam int PRE_HI_MSB    = 6;
  localparam int RES_LOW_MSB   = 2;

  localparam logic [2:0] SLEEP_CONT    = 3'h0;
  localparam logic [2:0] SLEEP_NO_LOOP = 3'h7;

  localparam logic [4:0] GAIN_CH_FIRST  = 5'h0a;
  localparam logic [4:0] GAIN_CH_LAST   = 5'h15;
  localparam logic [4:0] TOUCH_CH_LAST  = 5'h0d;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam int SLEEP_STEP_NS  = 4500000;
  localparam int SLEEP_STEP_CYC = SLEEP_STEP_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame: write flag, 10 address bits, 5 idle bits, 8 data bits.
  localparam logic [4:0] SPI_ADDR_DONE = 5'd10;
  localparam logic [4:0] SPI_DATA_FIRST = 5'd16;
  localparam logic [4:0] SPI_LAST_BIT  = 5'd23;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REQ, SEQ_WAIT, SEQ_SLEEP} acc_seq_state_t;

endpackage : acc_pkg

// ==== acc_regport_if.sv ====
`timescale 1ns/1ps
interface acc_regport_if;
  import acc_pkg::*;
  logic              wr_stb;
  logic              rd_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport port (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : acc_regport_if

// ==== acc_spi_port.sv ====
`timescale 1ns/1ps
module acc_spi_port
  import acc_pkg::*;
(
  input  wire logic   core_clk,    // System clock.
  input  wire logic   rst_n,       // Asynchronous reset, active low.
  input  wire logic   spi_cs_n,    // Frame select, active low.
  input  wire logic   spi_sclk,    // Serial clock, sampled as a level.
  input  wire logic   spi_mosi,    // Serial data in.
  output logic        spi_miso,    // Serial data out.
  output logic        spi_miso_oe, // High while the data out pin is driven.
  acc_regport_if.port bus          // Register strobes.
);

  typedef struct packed {
    logic        sclk_q;
    logic [4:0]  bit_cnt;
    logic [23:0] shift;
    logic        rd_frame;
    logic [7:0]  out;
    logic        wr_stb;
    logic        rd_stb;
    logic [9:0]  addr;
    logic [7:0]  wdata;
  } acc_spi_state_t;

  acc_spi_state_t st_r;
  acc_spi_state_t st_nxt;
  logic           rise;
  logic           fall;
  logic [23:0]    shifted;

  assign rise    = spi_sclk & ~st_r.sclk_q;
  assign fall    = ~spi_sclk & st_r.sclk_q;
  assign shifted = {st_r.shift[22:0], spi_mosi};

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.sclk_q = spi_sclk;
    st_nxt.wr_stb = 1'b0;
    st_nxt.rd_stb = 1'b0;
    if (st_r.rd_stb)
    begin
      st_nxt.out = bus.rdata;
    end
    if (spi_cs_n)
    begin
      st_nxt.bit_cnt  = 5'd0;
      st_nxt.rd_frame = 1'b0;
    end
    else if (rise)
    begin
      st_nxt.shift   = shifted;
      st_nxt.bit_cnt = st_r.bit_cnt + 5'd1;
      // The read is issued during the idle bits so data is ready well before its first edge.
      if (st_r.bit_cnt == SPI_ADDR_DONE && !shifted[10])
      begin
        st_nxt.addr     = shifted[9:0];
        st_nxt.rd_stb   = 1'b1;
        st_nxt.rd_frame = 1'b1;
      end
      if (st_r.bit_cnt == SPI_LAST_BIT && shifted[23])
      begin
        st_nxt.addr   = shifted[22:13];
        st_nxt.wdata  = shifted[7:0];
        st_nxt.wr_stb = 1'b1;
      end
    end
    else if (fall && st_r.bit_cnt > SPI_DATA_FIRST)
    begin
      st_nxt.out = {st_r.out[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bus.wr_stb  = st_r.wr_stb;
  assign bus.rd_stb  = st_r.rd_stb;
  assign bus.addr    = st_r.addr;
  assign bus.wdata   = st_r.wdata;
  assign spi_miso    = st_r.out[7];
  assign spi_miso_oe = st_r.rd_frame & ~spi_cs_n & (st_r.bit_cnt >= SPI_DATA_FIRST);

endmodule : acc_spi_port

// ==== acc_ctrl_asserts.sv ====
`timescale 1ns/1ps
module acc_ctrl_asserts (
  input wire logic       core_clk,           // Clock.
  input wire logic       rst_n,              // Reset.
  input wire logic       spi_cs_n,           // Select.
  input wire logic       spi_miso_oe,        // Out enable.
  input wire logic       conv_req,           // Request.
  input wire logic [4:0] conv_channel,       // Channel.
  input wire logic       conv_gain,          // Gain.
  input wire logic       conv_done,          // Done.
  input wire logic       x_pair_bias_on,     // X bias.
  input wire logic       y_pair_bias_on,     // Y bias.
  input wire logic       cross_pair_bias_on, // Cross bias.
  input wire logic       cycle_done,         // Cycle end.
  input wire logic       overflow_event      // Half scale.
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire bias = x_pair_bias_on | y_pair_bias_on | cross_pair_bias_on;
  a_req_held: assert property (conv_req && !conv_done |=> conv_req)
    else $error("request dropped early");
  a_req_release: assert property ($fell(conv_req) |-> $past(conv_done))
    else $error("request fell without done");
  a_slot_stable: assert property (conv_req && !conv_done |=>
    $stable({conv_channel, conv_gain}))
    else $error("channel or gain moved");
  a_bias_in_slot: assert property (bias |-> conv_req)
    else $error("bias outside conversion");
  a_touch_unity: assert property (conv_req && bias &&
    conv_channel inside {[10:13]} |-> !conv_gain)
    else $error("gain on biased channel");
  a_oe_framed: assert property (spi_miso_oe |-> !spi_cs_n)
    else $error("data out driven outside frame");
  a_ovf_pulse: assert property (overflow_event |=> !overflow_event)
    else $error("overflow event too long");
  a_cycle_pulse: assert property (cycle_done |=> !cycle_done)
    else $error("cycle done too long");
  c_conv: cover property (conv_req && conv_done);
  c_cycle: cover property (cycle_done);
  c_ovf: cover property (overflow_event);
endmodule : acc_ctrl_asserts

// ==== acc_host_model.sv ====
`timescale 1ns/1ps
module acc_host_model (
  input  wire logic core_clk, // Clock.
  output logic      spi_cs_n, // Select.
  output logic      spi_sclk, // Serial clock.
  output logic      spi_mosi, // Data to device.
  input  wire logic spi_miso  // Data from device.
);
  initial {spi_cs_n, spi_sclk, spi_mosi} = 3'b100;
  // Each sclk phase lasts two core cycles; the port needs only one, as it samples sclk on every core clock.
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] f;
    f = {w, a, 5'h00, d};
    q = 8'h00;
    @(posedge core_clk);
    #1 spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spi_mosi = f[i];
      repeat (2) @(posedge core_clk);
      if (i < 8) q[i] = spi_miso;
      #1 spi_sclk = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 spi_sclk = 1'b0;
    end
    repeat (2) @(posedge core_clk);
    #1 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (4) @(posedge core_clk);
  endtask : xfer
endmodule : acc_host_model

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  localparam int SLOTS = 4;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        conv_done = 1'b0;
  logic [9:0]  conv_result = 10'h000;
  logic        cc_up = 1'b0;
  logic        cc_down = 1'b0;
  logic        spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, conv_req, conv_gain;
  logic [4:0]  conv_channel;
  logic        converter_power_on, pen_bias_enable, x_pair_bias_on, y_pair_bias_on;
  logic        cross_pair_bias_on, supply_channel_enable, charge_current_channel_enable;
  logic        backup_cell_channel_enable, battery_detect_channel_enable, charge_count_run;
  logic        period_dither_enable, digital_correction_off, analog_offset_cal;
  logic        cycle_done, overflow_event;
  logic [7:0]  s [SLOTS];
  logic [10:0] res [32];
  logic [11:0] gn;
  logic [7:0]  v, q;
  int          seed, sl, nconv, ncyc, novf, n, fail_count, compares;

  acc_ctrl #(.SLEEP_STEP_CYCLES(20), .NUM_SLOTS(SLOTS)) i_acc_ctrl (.*);
  acc_host_model i_acc_host_model (.*);
  always #5 core_clk = ~core_clk;

  //////////////////////////////////////////////////////////////////////////
  // Pen bias stays on while the sequencer runs, so channels 10 to 13 are unity.
  function automatic logic eg(input logic [4:0] c);
    return c > 5'h0d && c <= 5'h15 && gn[c - 5'h0a];
  endfunction : eg
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xf(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
    i_acc_host_model.xfer(w, a, d, q);
    if (!w) chk(q, e);
  endtask : xf
  task automatic end_sim;
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  always
  begin
    @(posedge core_clk);
    #1 conv_done = 1'b0;
    if (conv_req && $random(seed) % 3 == 0)
    begin
      conv_done = 1'b1;
      conv_result = 10'($random(seed));
      chk(conv_channel, s[sl][4:0]);
      chk({conv_gain, cross_pair_bias_on, y_pair_bias_on, x_pair_bias_on},
          {eg(conv_channel), s[sl][7:5]});
      res[conv_channel] = {eg(conv_channel), conv_result};
      sl = (sl + 1) % SLOTS;
      nconv++;
    end
  end
  always @(negedge core_clk)
  begin
    novf += overflow_event;
    ncyc += cycle_done;
  end
  initial
  begin
    #800000;
    fail_count++;
    end_sim;
  end

  initial
  begin
    seed = 12151;
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    xf(0, ADDR_PRE_LO, 0, 8'h1a);
    xf(0, ADDR_SEQ_CTRL, 0, 0);
    xf(0, ADDR_CC_CTRL, 0, 0);
    xf(0, 10'h3ff, 0, 0);
    v = 8'($random(seed));
    xf(1, ADDR_EXTRA, v, 0);
    xf(0, ADDR_EXTRA, 0, v & 8'h0f);
    chk({battery_detect_channel_enable, backup_cell_channel_enable,
         charge_current_channel_enable, supply_channel_enable}, v[3:0]);
    xf(1, ADDR_CC_CTRL, (v & 8'h1c) | 8'h01, 0);
    chk({analog_offset_cal, digital_correction_off, period_dither_enable, charge_count_run},
        {v[4:2], 1'b1});
    xf(1, ADDR_PRE_LO, 3, 0);
    n = 5 + ($random(seed) & 3);
    #1 cc_up = 1'b1;
    repeat (3 * n) @(posedge core_clk);
    #1 cc_up = 1'b0;
    xf(0, ADDR_RAW_LO, 0, 8'(n));
    xf(1, ADDR_CC_CTRL, 8'h21, 0);
    xf(0, ADDR_CNT_LO, 0, 8'(-n));
    xf(0, ADDR_CNT_HI, 0, 8'hff);
    xf(0, ADDR_RAW_HI, 0, 0);
    xf(1, ADDR_SEQ_CTRL, 8'h30, 0);
    chk(pen_bias_enable, 1);
    xf(0, ADDR_SEQ_CTRL, 0, 8'h20);
    xf(0, ADDR_RAW_LO, 0, 0);
    xf(1, ADDR_PRE_LO, 1, 0);
    #1 cc_up = 1'b1;
    repeat (16384) @(posedge core_clk);
    #1 cc_up = 1'b0;
    xf(0, ADDR_RAW_HI, 0, 8'h40);
    chk(novf, 1);
    #1 cc_up = 1'b1;
    repeat (16384) @(posedge core_clk);
    #1 cc_up = 1'b0;
    xf(0, ADDR_CC_CTRL, 0, 8'ha1);
    gn = 12'($random(seed)) | 12'h012;
    xf(1, ADDR_GAIN_A, gn[7:0], 0);
    xf(1, ADDR_GAIN_B, {4'h0, gn[11:8]}, 0);
    xf(0, ADDR_GAIN_B, 0, {4'h0, gn[11:8]});
    for (int i = 0; i < SLOTS; i++)
    begin
      s[i] = i == 0 ? 8'h2b : i == 1 ? 8'h0e : 8'($random(seed));
      xf(1, 10'(ADDR_SLOT_BASE + i), s[i], 0);
    end
    xf(1, ADDR_SEQ_CTRL, 8'he7, 0);
    chk(converter_power_on, 1);
    for (int k = 0; k < 5000 && ncyc == 0; k++) @(posedge core_clk);
    repeat (300) @(posedge core_clk);
    chk(nconv, SLOTS);
    chk(ncyc, 1);
    xf(0, 10'(ADDR_RESULT_BASE + 2 * s[3][4:0]), 0, res[s[3][4:0]][10:3]);
    xf(0, 10'(ADDR_RESULT_BASE + 2 * s[3][4:0] + 1), 0, {5'h00, res[s[3][4:0]][2:0]});
    xf(1, ADDR_SEQ_CTRL, 8'he1, 0);
    for (int k = 0; k < 5000 && ncyc < 3; k++) @(posedge core_clk);
    repeat (19) @(posedge core_clk);
    #1 chk(conv_req, 0);
    @(posedge core_clk);
    #1 chk(conv_req, 1);
    xf(1, ADDR_SEQ_CTRL, 8'ha1, 0);
    repeat (400) @(posedge core_clk);
    chk(nconv, 4 * ncyc);
    end_sim;
  end
endmodule : tb

bind acc_ctrl acc_ctrl_asserts i_acc_ctrl_asserts (.*);
